// ---- start_seq_regs.svh ----
`ifndef START_SEQ_REGS_SVH
`define START_SEQ_REGS_SVH
// clock and settling timeout
`define CLK_MHZ 250
`define SETTLE_TIMEOUT_US 64000
`define SETTLE_TIMEOUT_CYC (`SETTLE_TIMEOUT_US * `CLK_MHZ)
`define PROBE_TIMEOUT_CYC 50000
`define TMR_W 24
// otp geometry and header flag words (word addresses)
`define OTP_AW 13
`define WCNT_W 14
`define OTP_FLAG1_ADDR 13'h1fc0
`define OTP_FLAG2_ADDR 13'h1fc1
`define APP_FLAG1 32'h1234a5a5
`define APP_FLAG2 32'ha5a51234
// probe sequence
`define PROBE_LAST 4'ha
`define PROBE_FIRST_UART 4'h2
`define PROBE_SPIS 4'h6
`define PROBE_FIRST_I2C 4'h7
// pin maps per step: {clk, sel, din, dout}, 3-bit port 0 pin numbers
`define MAP_SPIM_A 12'h0f5
`define MAP_SPIM_B 12'h053
`define MAP_UART_A 12'h008
`define MAP_UART_B 12'h01a
`define MAP_UART_C 12'h02c
`define MAP_UART_D 12'h03e
`define MAP_SPIS_A 12'h0f5
`define MAP_I2C_A 12'h009
`define MAP_I2C_B 12'h41b
`define MAP_I2C_C 12'h82d
`define MAP_I2C_D 12'hc3f
`endif

// ---- start_seq_pkg.sv ----
package start_seq_pkg;
  typedef enum logic [3:0] {
    ST_OFF, ST_CHECK, ST_BOOST_ON, ST_REG_ON, ST_XTAL_ON, ST_SETTLE,
    ST_MIRROR, ST_BOOT_F1, ST_BOOT_F2, ST_PROBE, ST_LINKED, ST_ACTIVE
  } state_t;
  typedef enum logic [1:0] {MODE_NONE, MODE_NORMAL, MODE_DEV, MODE_FAULTY} boot_mode_t;
  typedef enum logic [1:0] {IF_SPIM, IF_UART, IF_SPIS, IF_I2C} probe_if_t;
endpackage

// ---- system_start_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "start_seq_regs.svh"
module system_start_sequencer #(
  parameter int SETTLE_CYCLES = `SETTLE_TIMEOUT_CYC,
  parameter int PROBE_CYCLES = `PROBE_TIMEOUT_CYC
) (
  // clock and power-on / hardware reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // analog comparators and settled indications (asynchronous)
  input wire logic low_battery_input_i,
  input wire logic high_battery_input_i,
  input wire logic ldo_ok_i,
  input wire logic fast_crystal_osc_ok_i,
  input wire logic wake_i,
  // control bits
  input wire logic timeout_disable_i,
  input wire logic otp_copy_en_i,
  input wire logic force_boost_i,
  input wire logic force_buck_i,
  input wire logic sleep_req_i,
  input wire logic wcnt_load_i,
  input wire logic [`WCNT_W-1:0] wcnt_i,
  // analog enables
  output logic dcdc_en_o,
  output logic dcdc_boost_o,
  output logic bandgap_en_o,
  output logic core_ldo_en_o,
  output logic otp_ldo_en_o,
  output logic fast_crystal_osc_en_o,
  // status
  output logic cold_start_o,
  output logic settle_timeout_o,
  output logic cpu_run_o,
  output start_seq_pkg::boot_mode_t boot_mode_o,
  output logic [`WCNT_W-1:0] mirror_word_count_o,
  // otp read port
  output logic otp_rd_o,
  output logic [`OTP_AW-1:0] otp_addr_o,
  input wire logic otp_rvalid_i,
  input wire logic [31:0] otp_rdata_i,
  // system ram write port
  output logic sram_we_o,
  output logic [`OTP_AW-1:0] sram_addr_o,
  output logic [31:0] sram_wdata_o,
  // boot peripheral probing
  input wire logic probe_answer_i,
  output logic probe_send_o,
  output logic [3:0] probe_step_o,
  output start_seq_pkg::probe_if_t probe_if_o,
  output logic [11:0] probe_map_o,
  output logic probe_linked_o
);
  import start_seq_pkg::*;

  localparam logic [`TMR_W-1:0] SETTLE_LIM = SETTLE_CYCLES[`TMR_W-1:0];
  localparam logic [`TMR_W-1:0] PROBE_LIM = PROBE_CYCLES[`TMR_W-1:0];

  state_t state_q, state_d;
  logic [4:0] async_w, sync1_q, sync2_q;
  logic low_s, high_s, ldo_s, xtal_s, wake_s;
  logic [`TMR_W-1:0] tmr_q, ptmr_q;
  logic [`WCNT_W-1:0] idx_q;
  logic [`WCNT_W-1:0] wr_cnt_q;
  logic pend_q;
  logic [31:0] flag1_q;
  logic [3:0] step_q;
  logic [11:0] pin_map [0:10];

  // two-flop synchronisers, one per asynchronous input
  // no reset on purpose: they keep tracking the pins through reset, so the
  // supply check on the first edge after release sees real comparator levels
  assign async_w = {wake_i, fast_crystal_osc_ok_i, ldo_ok_i, high_battery_input_i, low_battery_input_i};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        sync1_q[gi] <= async_w[gi];
        sync2_q[gi] <= sync1_q[gi];
      end
    end
  endgenerate
  assign {wake_s, xtal_s, ldo_s, high_s, low_s} = sync2_q;

  // supply decision: forcing beats the comparators
  wire boost_first = force_boost_i | (!force_buck_i & low_s);
  wire boost_second = force_boost_i | (!force_buck_i & !high_s & low_s);
  wire settle_ok = ldo_s & xtal_s;
  wire settle_to = !timeout_disable_i & (tmr_q == SETTLE_LIM);
  wire settle_done = settle_ok | settle_to;

  // otp read requests: one outstanding at a time
  wire mirror_more = otp_copy_en_i & (idx_q != mirror_word_count_o);
  wire need_read = ((state_q == ST_MIRROR) & mirror_more) | (state_q == ST_BOOT_F1) | (state_q == ST_BOOT_F2);
  wire issue = need_read & !pend_q;
  wire mirror_done = (state_q == ST_MIRROR) & !mirror_more & !pend_q;
  wire app_ok = (flag1_q == `APP_FLAG1) & (otp_rdata_i == `APP_FLAG2);
  wire otp_blank = (flag1_q == 32'h0000_0000) & (otp_rdata_i == 32'h0000_0000);
  wire boot_rx = (state_q == ST_BOOT_F2) & otp_rvalid_i;

  // probe stepping, wraps to the first step after the last
  wire [3:0] step_next = (step_q == `PROBE_LAST) ? 4'h0 : step_q + 4'h1;
  wire probe_to = (state_q == ST_PROBE) & !probe_answer_i & (ptmr_q == PROBE_LIM);
  wire probe_enter = boot_rx & !app_ok;
  wire [3:0] step_new = probe_enter ? 4'h0 : step_next;

  // pin set table
  assign pin_map[0] = `MAP_SPIM_A;
  assign pin_map[1] = `MAP_SPIM_B;
  assign pin_map[2] = `MAP_UART_A;
  assign pin_map[3] = `MAP_UART_B;
  assign pin_map[4] = `MAP_UART_C;
  assign pin_map[5] = `MAP_UART_D;
  assign pin_map[6] = `MAP_SPIS_A;
  assign pin_map[7] = `MAP_I2C_A;
  assign pin_map[8] = `MAP_I2C_B;
  assign pin_map[9] = `MAP_I2C_C;
  assign pin_map[10] = `MAP_I2C_D;
  wire probe_if_t if_new = (step_new < `PROBE_FIRST_UART) ? IF_SPIM :
                           (step_new < `PROBE_SPIS) ? IF_UART :
                           (step_new < `PROBE_FIRST_I2C) ? IF_SPIS : IF_I2C;

  // stage sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: if (wake_s) state_d = ST_CHECK;
      ST_CHECK: state_d = boost_first ? ST_BOOST_ON : ST_REG_ON;
      ST_BOOST_ON: state_d = ST_REG_ON;
      ST_REG_ON: state_d = ST_XTAL_ON;
      ST_XTAL_ON: state_d = ST_SETTLE;
      ST_SETTLE: if (settle_done) state_d = cold_start_o ? ST_BOOT_F1 : ST_MIRROR;
      ST_MIRROR: if (mirror_done) state_d = ST_ACTIVE;
      ST_BOOT_F1: if (otp_rvalid_i) state_d = ST_BOOT_F2;
      ST_BOOT_F2: if (otp_rvalid_i) state_d = app_ok ? ST_ACTIVE : ST_PROBE;
      ST_PROBE: if (probe_answer_i) state_d = ST_LINKED;
      ST_LINKED: state_d = ST_LINKED;
      ST_ACTIVE: if (sleep_req_i) state_d = ST_OFF;
    endcase
  end

  // reset lands straight in the supply check: a cold start
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) state_q <= ST_CHECK;
    else state_q <= state_d;
  end

  // cold flag only cleared once boot has handed over; a wake keeps it low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) cold_start_o <= 1'b1;
    else if (boot_rx) cold_start_o <= 1'b0;
  end

  // analog enables, all dropped while asleep
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {dcdc_en_o, dcdc_boost_o, bandgap_en_o, core_ldo_en_o, otp_ldo_en_o} <= 5'h00;
      fast_crystal_osc_en_o <= 1'b0;
    end else if (state_q == ST_OFF) begin
      {dcdc_en_o, dcdc_boost_o, bandgap_en_o, core_ldo_en_o, otp_ldo_en_o} <= 5'h00;
      fast_crystal_osc_en_o <= 1'b0;
    end else if (state_q == ST_CHECK) begin
      dcdc_en_o <= boost_first;
      dcdc_boost_o <= boost_first;
    end else if (state_q == ST_REG_ON) begin
      {dcdc_en_o, bandgap_en_o, core_ldo_en_o, otp_ldo_en_o} <= 4'hf;
    end else if (state_q == ST_XTAL_ON) begin
      fast_crystal_osc_en_o <= 1'b1;
      dcdc_boost_o <= boost_second;
    end
  end

  // settling timer and timeout flag; 24 bits cover 64 ms at 250 MHz
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_q <= '0;
      settle_timeout_o <= 1'b0;
    end else begin
      tmr_q <= (state_q == ST_SETTLE && !settle_done) ? tmr_q + 1'b1 : '0;
      if (state_q == ST_CHECK) settle_timeout_o <= 1'b0;
      else if (state_q == ST_SETTLE && settle_to && !settle_ok) settle_timeout_o <= 1'b1;
    end
  end

  // word count lives only under power-on reset so it survives sleep
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) mirror_word_count_o <= '0;
    else if (wcnt_load_i) mirror_word_count_o <= wcnt_i;
  end

  // otp request port; the address follows the stage asking
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q <= 1'b0;
      otp_rd_o <= 1'b0;
      otp_addr_o <= '0;
    end else begin
      pend_q <= issue | (pend_q & !otp_rvalid_i);
      otp_rd_o <= issue;
      if (issue) otp_addr_o <= (state_q == ST_MIRROR) ? idx_q[`OTP_AW-1:0] :
                               (state_q == ST_BOOT_F1) ? `OTP_FLAG1_ADDR : `OTP_FLAG2_ADDR;
    end
  end

  // wake-up mirror engine: each returned word goes straight to ram
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_q <= '0;
      sram_we_o <= 1'b0;
      sram_addr_o <= '0;
      sram_wdata_o <= '0;
    end else begin
      sram_we_o <= (state_q == ST_MIRROR) & otp_rvalid_i;
      if (state_q != ST_MIRROR) idx_q <= '0;
      else if (otp_rvalid_i) begin
        idx_q <= idx_q + 1'b1;
        sram_addr_o <= idx_q[`OTP_AW-1:0];
        sram_wdata_o <= otp_rdata_i;
      end
    end
  end

  // ram writes seen in the current mirror pass; lets the count check see real pulses
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) wr_cnt_q <= '0;
    else if (state_q != ST_MIRROR) wr_cnt_q <= '0;
    else if (sram_we_o) wr_cnt_q <= wr_cnt_q + 1'b1;
  end

  // boot decision from the two application flags
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag1_q <= '0;
      boot_mode_o <= MODE_NONE;
    end else begin
      if (state_q == ST_BOOT_F1 && otp_rvalid_i) flag1_q <= otp_rdata_i;
      if (boot_rx) boot_mode_o <= app_ok ? MODE_NORMAL : otp_blank ? MODE_DEV : MODE_FAULTY;
    end
  end

  // cpu runs once a stage hands over control
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) cpu_run_o <= 1'b0;
    else cpu_run_o <= (state_d == ST_ACTIVE) | (state_d == ST_LINKED);
  end

  // probe sequencer; step, interface and pin set move together
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_q <= 4'h0;
      ptmr_q <= '0;
      probe_send_o <= 1'b0;
      probe_if_o <= IF_SPIM;
      probe_map_o <= 12'h000;
      probe_linked_o <= 1'b0;
    end else begin
      probe_send_o <= probe_enter | probe_to;
      ptmr_q <= (state_q == ST_PROBE && !probe_to) ? ptmr_q + 1'b1 : '0;
      probe_linked_o <= (state_d == ST_LINKED);
      if (probe_enter || probe_to) begin
        step_q <= step_new;
        probe_if_o <= if_new;
        probe_map_o <= pin_map[step_new];
      end
    end
  end
  assign probe_step_o = step_q;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // stage order and the cold/warm split
  chk_stage_order: assert property ($changed(state_q) && (state_q == ST_MIRROR || state_q == ST_BOOT_F1)
    |-> $past(state_q) == ST_SETTLE) else $error("stage entered out of order");
  chk_no_wake_boot: assert property (state_q == ST_BOOT_F1 |-> cold_start_o)
    else $error("boot stage reached without cold start");
  chk_wake_mirror: assert property (state_q == ST_SETTLE && settle_done && !cold_start_o
    |=> state_q == ST_MIRROR) else $error("wake did not go to mirroring");
  chk_sleep_off: assert property (state_q == ST_OFF
    |=> !dcdc_en_o && !bandgap_en_o && !core_ldo_en_o && !otp_ldo_en_o && !fast_crystal_osc_en_o)
    else $error("supplies left on in sleep");

  // supply bring-up
  chk_boost_first: assert property (state_q == ST_CHECK && boost_first
    |=> dcdc_en_o && dcdc_boost_o ##1 state_q == ST_REG_ON) else $error("boost not started first");
  chk_regs_then_xtal: assert property (state_q == ST_REG_ON
    |=> bandgap_en_o && core_ldo_en_o && otp_ldo_en_o ##1 fast_crystal_osc_en_o) else $error("enable order");
  chk_second_check: assert property (state_q == ST_XTAL_ON |=> dcdc_boost_o == $past(boost_second))
    else $error("second supply check lost");

  // settle wait
  chk_wait_forever: assert property (state_q == ST_SETTLE && timeout_disable_i && !settle_ok
    |=> state_q == ST_SETTLE) else $error("left settle with timeout off");
  chk_timeout_exit: assert property (state_q == ST_SETTLE && tmr_q == SETTLE_LIM
    && !timeout_disable_i && !settle_ok |=> state_q != ST_SETTLE && settle_timeout_o)
    else $error("settle timeout missed");

  // otp mirror and boot decision
  chk_mirror_count: assert property (mirror_done && otp_copy_en_i |=> wr_cnt_q == mirror_word_count_o)
    else $error("mirror word count wrong");
  chk_normal_mode: assert property (boot_rx && app_ok |=> boot_mode_o == MODE_NORMAL && cpu_run_o)
    else $error("normal mode not selected");

  // probe walk
  chk_probe_enter: assert property (probe_enter
    |=> probe_send_o && probe_step_o == 4'h0 && probe_if_o == IF_SPIM && probe_map_o == `MAP_SPIM_A)
    else $error("probe did not start on the first step");
  chk_probe_step: assert property (probe_to |=> probe_send_o && probe_step_o == $past(step_next))
    else $error("probe step did not advance");
  chk_link_found: assert property (state_q == ST_PROBE && probe_answer_i
    |=> state_q == ST_LINKED && probe_linked_o && cpu_run_o) else $error("boot answer not taken");

  // main scenarios
  cov_cold_normal: cover property (boot_rx && app_ok);
  cov_wake_mirror: cover property (mirror_done && !cold_start_o);
  cov_probe_link: cover property (state_q == ST_PROBE ##1 state_q == ST_LINKED);
  cov_settle_timeout: cover property (state_q == ST_SETTLE && settle_to && !settle_ok);
  cov_boost_start: cover property (state_q == ST_CHECK && boost_first);
endmodule
`default_nettype wire

// ---- otp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module otp_host_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // otp read port
  input wire logic otp_rd_i,
  input wire logic [12:0] otp_addr_i,
  input wire logic [2:0] lat_i,
  output logic otp_rvalid_o,
  output logic [31:0] otp_rdata_o,
  // boot host side
  input wire logic probe_send_i,
  input wire logic [3:0] probe_step_i,
  input wire logic [3:0] answer_step_i,
  output logic probe_answer_o
);
  logic [31:0] mem [0:8191];
  logic [12:0] addr_q;
  logic [3:0] wait_q;
  // one read in flight; data toggles outside the valid cycle so stale words never match
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 4'h0;
      otp_rvalid_o <= 1'b0;
      otp_rdata_o <= 32'h0;
      probe_answer_o <= 1'b0;
    end else begin
      otp_rvalid_o <= 1'b0;
      otp_rdata_o <= ~otp_rdata_o;
      if (otp_rd_i) begin
        addr_q <= otp_addr_i;
        wait_q <= {1'b0, lat_i};
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      if (!otp_rd_i && wait_q == 4'h1) begin
        otp_rvalid_o <= 1'b1;
        otp_rdata_o <= mem[addr_q];
      end
      // host answers on its own step only, long before the step times out
      if (probe_send_i && probe_step_i == answer_step_i) probe_answer_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- system_start_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_start_sequencer_tb;
  import start_seq_pkg::*;
  localparam int SETTLE = 50;
  // stimulus and observed signals
  logic clock_i = 1'b0;
  logic nrst_i, low_bat, high_bat, ldo_ok, xtal_ok, wake, to_dis, copy_en, f_boost, f_buck, sleep_req, ld;
  logic [13:0] wcnt, mirror_word_count_o;
  logic dcdc_en_o, dcdc_boost_o, bg_o, core_o, otpl_o, xtal_o, cold_o, tmo_o, run_o, rd_o, rv, we_o, ans, send_o, link_o;
  boot_mode_t mode_o;
  probe_if_t if_o;
  logic [12:0] addr_o, waddr_o;
  logic [31:0] rdata, wdata_o;
  logic [11:0] map_o;
  logic [3:0] step_o, ans_step;
  logic [2:0] lat;
  logic [44:0] exp_wr[$];
  logic [17:0] exp_pr[$];
  int fails = 0;
  int n_checks = 0;
  int n_rd = 0;
  int i, k, n;
  system_start_sequencer #(.SETTLE_CYCLES(SETTLE), .PROBE_CYCLES(20)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .low_battery_input_i(low_bat), .high_battery_input_i(high_bat),
    .ldo_ok_i(ldo_ok), .fast_crystal_osc_ok_i(xtal_ok), .wake_i(wake), .timeout_disable_i(to_dis),
    .otp_copy_en_i(copy_en), .force_boost_i(f_boost), .force_buck_i(f_buck), .sleep_req_i(sleep_req),
    .wcnt_load_i(ld), .wcnt_i(wcnt), .dcdc_en_o(dcdc_en_o), .dcdc_boost_o(dcdc_boost_o), .bandgap_en_o(bg_o),
    .core_ldo_en_o(core_o), .otp_ldo_en_o(otpl_o), .fast_crystal_osc_en_o(xtal_o), .cold_start_o(cold_o),
    .settle_timeout_o(tmo_o), .cpu_run_o(run_o), .boot_mode_o(mode_o), .mirror_word_count_o(mirror_word_count_o),
    .otp_rd_o(rd_o), .otp_addr_o(addr_o), .otp_rvalid_i(rv), .otp_rdata_i(rdata), .sram_we_o(we_o),
    .sram_addr_o(waddr_o), .sram_wdata_o(wdata_o), .probe_answer_i(ans), .probe_send_o(send_o),
    .probe_step_o(step_o), .probe_if_o(if_o), .probe_map_o(map_o), .probe_linked_o(link_o));
  otp_host_model otp_host (
    .clock_i(clock_i), .nrst_i(nrst_i), .otp_rd_i(rd_o), .otp_addr_i(addr_o), .lat_i(lat), .otp_rvalid_o(rv),
    .otp_rdata_o(rdata), .probe_send_i(send_o), .probe_step_i(step_o), .answer_step_i(ans_step),
    .probe_answer_o(ans));
  always #2 clock_i = ~clock_i;
  task automatic err(input string msg);
    fails++;
    $display("unexpected %0t %s", $time, msg);
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_checks++;
    if (got !== exp) err(msg);
  endtask
  task automatic cmp_wr(input logic [44:0] got, input logic [44:0] exp);
    n_checks++;
    if (got !== exp) err("ram write");
  endtask
  task automatic cmp_pr(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) err("probe step");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // expected {step, interface, clk, sel, din, dout} for each probe step
  function automatic logic [17:0] eprobe(input int s);
    int j;
    j = (s < 2) ? s : (s < 6) ? s - 2 : s - 7;
    if (s == 6) return {4'h6, IF_SPIS, 3'h0, 3'h3, 3'h6, 3'h5};
    if (s < 2) return {4'(s), IF_SPIM, 3'h0, (j ? 3'h1 : 3'h3), (j ? 3'h2 : 3'h6), (j ? 3'h3 : 3'h5)};
    if (s < 6) return {4'(s), IF_UART, 6'h0, 3'(2 * j + 1), 3'(2 * j)};
    return {4'(s), IF_I2C, 3'(2 * j), 3'h0, 3'(2 * j + 1), 3'(2 * j + 1)};
  endfunction
  // result watcher: every write and probe pulse takes the oldest note
  always @(posedge clock_i) begin
    if (nrst_i) begin
      if (rd_o) n_rd++;
      if (we_o && exp_wr.size() == 0) err("stray ram write");
      else if (we_o) cmp_wr({waddr_o, wdata_o}, exp_wr.pop_front());
      if (send_o && exp_pr.size() == 0) err("stray probe");
      else if (send_o) cmp_pr({step_o, if_o, map_o}, exp_pr.pop_front());
    end
  end
  task automatic do_reset();
    nrst_i = 1'b0;
    n_rd = 0;
    repeat (5) @(negedge clock_i);
    cmp({cold_o, dcdc_en_o, mode_o}, {1'b1, 1'b0, MODE_NONE}, "in reset");
    nrst_i = 1'b1;
  endtask
  task automatic sleep_wake(input int nr);
    sleep_req = 1'b1;
    @(negedge clock_i);
    sleep_req = 1'b0;
    repeat (3) @(negedge clock_i);
    cmp({dcdc_en_o, bg_o, core_o, otpl_o, xtal_o, run_o}, 0, "sleep");
    n_rd = 0;
    wake = 1'b1;
    repeat (3) @(negedge clock_i);
    wake = 1'b0;
    for (i = 0; i < 300 && run_o !== 1'b1; i++) @(negedge clock_i);
    cmp({run_o, cold_o, mode_o}, {1'b1, 1'b0, MODE_NORMAL}, "wake");
    cmp(n_rd, nr, "mirror reads");
    cmp(exp_wr.size(), 0, "mirror writes");
  endtask
  // watchdog at 10000 cycles, well beyond the several hundred cycles the run needs
  initial begin
    #40000;
    err("watchdog");
    finish_test();
  end
  initial begin
    void'($urandom(32'h3057));
    {nrst_i, low_bat, high_bat, ldo_ok, xtal_ok, wake, to_dis, copy_en, f_boost, f_buck, sleep_req, ld} = 12'h0;
    wcnt = 14'h0;
    lat = 3'h1;
    ans_step = 4'hf;
    // cold start on boost, settling runs into its timeout, blank otp
    otp_host.mem[13'h1fc0] = 32'h0;
    otp_host.mem[13'h1fc1] = 32'h0;
    for (k = 0; k < 12; k++) exp_pr.push_back(eprobe(k % 11));
    low_bat = 1'b1;
    do_reset();
    for (i = 0; i < 20 && dcdc_en_o !== 1'b1; i++) @(negedge clock_i);
    cmp({dcdc_boost_o, bg_o}, 2'h2, "boost first");
    repeat (2) @(negedge clock_i);
    cmp({bg_o, core_o, otpl_o, xtal_o}, 4'he, "regulators");
    @(negedge clock_i);
    cmp({xtal_o, dcdc_boost_o}, 2'h3, "crystal");
    for (i = 0; i < 80 && tmo_o !== 1'b1; i++) @(negedge clock_i);
    cmp(i >= SETTLE - 2 && i <= SETTLE + 5 && tmo_o === 1'b1, 1, "settle timeout");
    for (i = 0; i < 40 && mode_o === MODE_NONE; i++) @(negedge clock_i);
    cmp({mode_o, cold_o}, {MODE_DEV, 1'b0}, "dev mode");
    cmp(n_rd, 2, "flag reads");
    for (i = 0; i < 400 && exp_pr.size() != 0; i++) @(negedge clock_i);
    cmp({exp_pr.size(), link_o, run_o}, 0, "probe walk");
    // buck comparators, forcing both ways, unbounded wait, then wake mirroring
    {low_bat, high_bat, to_dis, f_boost, f_buck} = 5'h0f;
    otp_host.mem[13'h1fc0] = 32'h1234a5a5;
    otp_host.mem[13'h1fc1] = 32'ha5a51234;
    do_reset();
    repeat (SETTLE + 30) @(negedge clock_i);
    cmp({tmo_o, dcdc_boost_o, n_rd}, {1'b0, 1'b1, 32'd0}, "no timeout");
    {ldo_ok, xtal_ok} = 2'h3;
    for (i = 0; i < 40 && mode_o === MODE_NONE; i++) @(negedge clock_i);
    repeat (2) @(negedge clock_i);
    cmp({mode_o, run_o, n_rd}, {MODE_NORMAL, 1'b1, 32'd2}, "normal mode");
    n = $urandom_range(3, 9);
    wcnt = 14'(n);
    ld = 1'b1;
    @(negedge clock_i);
    ld = 1'b0;
    @(negedge clock_i);
    cmp(mirror_word_count_o, n, "word count");
    for (k = 0; k < n; k++) begin
      otp_host.mem[k] = $urandom;
      exp_wr.push_back({13'(k), otp_host.mem[k]});
    end
    copy_en = 1'b1;
    sleep_wake(n);
    copy_en = 1'b0;
    sleep_wake(0);
    // faulty otp, forced buck over comparators, slow otp, host answers on step 8
    {low_bat, to_dis, f_boost, f_buck} = 4'h9;
    lat = 3'($urandom_range(2, 4));
    otp_host.mem[13'h1fc0] = $urandom | 32'h1;
    otp_host.mem[13'h1fc1] = $urandom;
    ans_step = 4'h8;
    for (k = 0; k < 9; k++) exp_pr.push_back(eprobe(k));
    do_reset();
    repeat (8) @(negedge clock_i);
    cmp(dcdc_boost_o, 0, "forced buck");
    for (i = 0; i < 400 && link_o !== 1'b1; i++) @(negedge clock_i);
    repeat (30) @(negedge clock_i);
    cmp({link_o, run_o, mode_o, step_o, exp_pr.size()}, {2'h3, MODE_FAULTY, 4'h8, 32'd0}, "linked");
    finish_test();
  end
endmodule
`default_nettype wire
